// *** hw/cpsr_pkg.sv ***
// Purpose: Constants for the copper port status register block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Register indices are scaled by four to give byte addresses.
package cpsr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STAT_W = 16;
    // Printed index of the status register and of the added registers.
    localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h11;
    localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h10;
    localparam logic [ADDR_W-1:0] IDX_EVENT = 8'h13;
    localparam logic [ADDR_W-1:0] IDX_MASK = 8'h12;
    // Field positions of the status word.
    localparam int B_SPEED_HI = 15;
    localparam int B_SPEED_LO = 14;
    localparam int B_DUPLEX = 13;
    localparam int B_PAGE = 12;
    localparam int B_RESOLVED = 11;
    localparam int B_LINK_RT = 10;
    localparam int B_TX_PAUSE = 9;
    localparam int B_RX_PAUSE = 8;
    localparam int B_RSVD = 7;
    localparam int B_XOVER = 6;
    localparam int B_DOWNSHIFT = 5;
    localparam int B_SLEEP = 4;
    localparam int B_LINK_GLOBAL = 3;
    localparam int B_DTE_POWER = 2;
    localparam int B_POLARITY = 1;
    localparam int B_JABBER = 0;
    // Control register fields.
    localparam int C_XMODE_HI = 6;
    localparam int C_XMODE_LO = 5;
    localparam int C_POL_DIS = 1;
    // Reset values.
    localparam logic [1:0] SPEED_RST = 2'h2;
    localparam logic XOVER_RST = 1'b1;
    localparam logic [1:0] XMODE_RST = 2'h3;
    // Speed and crossover mode codes.
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    localparam logic [1:0] XMODE_MDI = 2'h0;
    localparam logic [1:0] XMODE_MDIX = 2'h1;
    localparam logic [1:0] XMODE_AUTO = 2'h3;
endpackage

// *** hw/cpsr_status.sv ***
// Purpose: Copper port status register with APB access and an interrupt.
// Assumes: PHY state inputs are synchronous to clk; sw_reset is a pulse.
// Notes: Slave answers with zero wait states; unmapped reads give zero.
`timescale 1ns/1ps
//
// Contract
// - Speed field at 15:14, reset 2
// - Duplex at bit 13, reset 0
// - Resolved flag on AN done or disabled
// - Page received latched until read
// - Global link bit 3, real-time link 10
// - Pause bits 9 and 8 informational only
// - Crossover bit 6, manual follows mode
// - DTE power need at bit 2
// - Real-time receive polarity at bit 1
// - Polarity disable forces normal in 10BASE-T
// - Crossover mode codes 00,01,11
module cpsr_status
    import cpsr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cpsr_pkg::ADDR_W-1:0] paddr,
    input wire logic [cpsr_pkg::DATA_W-1:0] pwdata,
    output logic [cpsr_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // PHY state.
    input wire logic an_enable,
    input wire logic an_complete,
    input wire logic page_rx,
    input wire logic [1:0] speed_in,
    input wire logic duplex_in,
    input wire logic link_rt_in,
    input wire logic link_global_in,
    input wire logic tx_pause_in,
    input wire logic rx_pause_in,
    input wire logic xover_auto_in,
    input wire logic downshift_in,
    input wire logic sleep_in,
    input wire logic dte_power_in,
    input wire logic polarity_in,
    input wire logic jabber_in,
    // Applied crossover mode and interrupt.
    output logic [1:0] xover_mode,
    output logic irq
);
    import cpsr_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] idx);
        hit = (a == {idx[ADDR_W-3:0], 2'b00});
    endfunction

    logic [STAT_W-1:0] ctrl_reg;
    logic [1:0] xmode_reg;
    logic [1:0] speed_reg;
    logic duplex_reg;
    logic resolved_reg;
    logic page_reg;
    logic xover_reg;
    logic [STAT_W-1:0] status_word;
    logic [STAT_W-1:0] event_reg;
    logic [STAT_W-1:0] mask_reg;
    logic [STAT_W-1:0] prev_reg;
    logic [STAT_W-1:0] event_set;
    logic wr_en;
    logic rd_en;
    logic status_read;
    logic pol_eff;
    logic xover_next;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign status_read = rd_en && hit(paddr, IDX_STATUS);
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Control register; the crossover mode is applied on software reset.
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_reg <= {9'h000, XMODE_RST, 5'h00};
        else if (wr_en && hit(paddr, IDX_CTRL))
            ctrl_reg <= pwdata[STAT_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            xmode_reg <= XMODE_RST;
        else if (sw_reset)
            xmode_reg <= ctrl_reg[C_XMODE_HI:C_XMODE_LO];
    end
    assign xover_mode = xmode_reg;

    // Speed and duplex keep their value across software reset.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            speed_reg <= SPEED_RST;
            duplex_reg <= 1'b0;
        end
        else if (!sw_reset)
        begin
            speed_reg <= speed_in;
            duplex_reg <= duplex_in;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || sw_reset)
            resolved_reg <= 1'b0;
        else
            resolved_reg <= !an_enable || an_complete;
    end

    // A page arriving during the clearing read is kept.
    always_ff @(posedge clk)
    begin
        if (rst || sw_reset)
            page_reg <= 1'b0;
        else if (page_rx)
            page_reg <= 1'b1;
        else if (status_read)
            page_reg <= 1'b0;
    end

    always_comb
    begin
        case (xmode_reg)
            XMODE_MDI: xover_next = 1'b0;
            XMODE_MDIX: xover_next = 1'b1;
            XMODE_AUTO: xover_next = xover_auto_in;
            default: xover_next = xover_reg;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            xover_reg <= XOVER_RST;
        else
            xover_reg <= xover_next;
    end

    // Polarity shows normal when reversal is disabled at 10 Mbps.
    assign pol_eff = polarity_in &&
        !(ctrl_reg[C_POL_DIS] && speed_reg == SPEED_10);

    always_comb
    begin
        status_word = '0;
        status_word[B_SPEED_HI:B_SPEED_LO] = speed_reg;
        status_word[B_DUPLEX] = duplex_reg;
        status_word[B_PAGE] = page_reg;
        status_word[B_RESOLVED] = resolved_reg;
        status_word[B_LINK_RT] = link_rt_in;
        status_word[B_TX_PAUSE] = tx_pause_in;
        status_word[B_RX_PAUSE] = rx_pause_in;
        status_word[B_RSVD] = 1'b0;
        status_word[B_XOVER] = xover_reg;
        status_word[B_DOWNSHIFT] = downshift_in;
        status_word[B_SLEEP] = sleep_in;
        status_word[B_LINK_GLOBAL] = link_global_in;
        status_word[B_DTE_POWER] = dte_power_in;
        status_word[B_POLARITY] = pol_eff;
        status_word[B_JABBER] = jabber_in;
    end

    // Previous word resets to speed 2 and crossover 1 with every other field zero.
    always_ff @(posedge clk)
    begin
        if (rst)
            prev_reg <= {SPEED_RST, 7'h00, XOVER_RST, 6'h00};
        else
            prev_reg <= status_word;
    end

    // Any change of a status bit is an event; reserved bit never changes.
    assign event_set = status_word ^ prev_reg;

    genvar gi;
    generate
        for (gi = 0; gi < STAT_W; gi++)
        begin : g_evt
            always_ff @(posedge clk)
            begin
                if (rst)
                    event_reg[gi] <= 1'b0;
                else if (event_set[gi])
                    event_reg[gi] <= 1'b1;
                else if (wr_en && hit(paddr, IDX_EVENT) && pwdata[gi])
                    event_reg[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
            mask_reg <= '0;
        else if (wr_en && hit(paddr, IDX_MASK))
            mask_reg <= pwdata[STAT_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(event_reg & mask_reg);
    end

    // Read data decoded combinationally from paddr; it is not registered.
    always_comb
    begin
        prdata = '0;
        if (hit(paddr, IDX_STATUS))
            prdata[STAT_W-1:0] = status_word;
        else if (hit(paddr, IDX_CTRL))
            prdata[STAT_W-1:0] = ctrl_reg;
        else if (hit(paddr, IDX_EVENT))
            prdata[STAT_W-1:0] = event_reg;
        else if (hit(paddr, IDX_MASK))
            prdata[STAT_W-1:0] = mask_reg;
    end
endmodule // cpsr_status

// *** sim/cpsr_phy_model.sv ***
// Purpose: PHY-side source of the live status levels.
// Assumes: One packed word sets every level at once.
// Notes: Bit order of the word follows the status word.
`timescale 1ns/1ps
module cpsr_phy_model (
    // Packed levels.
    input wire logic [15:0] st,
    // Levels towards the block.
    output logic [1:0] speed_in,
    output logic duplex_in,
    output logic page_rx,
    output logic an_complete,
    output logic link_rt_in,
    output logic tx_pause_in,
    output logic rx_pause_in,
    output logic an_enable,
    output logic xover_auto_in,
    output logic downshift_in,
    output logic sleep_in,
    output logic link_global_in,
    output logic dte_power_in,
    output logic polarity_in,
    output logic jabber_in
);
    assign {speed_in, duplex_in, page_rx, an_complete, link_rt_in,
        tx_pause_in, rx_pause_in, an_enable, xover_auto_in, downshift_in,
        sleep_in, link_global_in, dte_power_in, polarity_in,
        jabber_in} = st;
endmodule // cpsr_phy_model

// *** sim/cpsr_status_asserts.sv ***
// Purpose: Port-level checks of the status register.
// Assumes: Status reads are combinational from paddr.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module cpsr_status_asserts
    import cpsr_pkg::*;
(
    // Clock and resets.
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_reset,
    // Read path.
    input wire logic [cpsr_pkg::ADDR_W-1:0] paddr,
    input wire logic [cpsr_pkg::DATA_W-1:0] prdata,
    // Levels and mode.
    input wire logic an_enable,
    input wire logic page_rx,
    input wire logic link_rt_in,
    input wire logic link_global_in,
    input wire logic tx_pause_in,
    input wire logic rx_pause_in,
    input wire logic dte_power_in,
    input wire logic jabber_in,
    input wire logic [1:0] xover_mode
);
    import cpsr_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic st_sel;
    assign st_sel = paddr == (IDX_STATUS << 2);
    sequence quiet;
        !$past(rst) && !$past(sw_reset);
    endsequence
    rsvd_bits_a:
        assert property (st_sel |-> !prdata[B_RSVD] && !prdata[31:16])
        else $error("reserved status bits set");
    link_live_a:
        assert property (st_sel |-> prdata[B_LINK_RT] == link_rt_in
            && prdata[B_LINK_GLOBAL] == link_global_in)
        else $error("link bits do not follow inputs");
    pause_mirror_a:
        assert property (st_sel |-> prdata[9:8] == {tx_pause_in, rx_pause_in})
        else $error("pause bits do not follow inputs");
    dte_power_a:
        assert property (st_sel |-> prdata[B_DTE_POWER] == dte_power_in)
        else $error("power need bit wrong");
    jabber_live_a:
        assert property (st_sel |-> prdata[B_JABBER] == jabber_in)
        else $error("jabber bit wrong");
    resolved_set_a:
        assert property (quiet ##0 (st_sel && !$past(an_enable))
            |-> prdata[B_RESOLVED])
        else $error("resolved flag low with negotiation off");
    page_latch_a:
        assert property (quiet ##0 (st_sel && $past(page_rx))
            |-> prdata[B_PAGE])
        else $error("page bit not latched");
    xmode_reset_a:
        assert property ($past(rst) |-> xover_mode == XMODE_RST)
        else $error("crossover mode not reset to auto");
endmodule // cpsr_status_asserts
bind cpsr_status cpsr_status_asserts chk_u (.*);

// *** sim/cpsr_status_tb.sv ***
// Purpose: Self-checking bench for the status register block.
// Assumes: Zero-wait APB slave.
// Notes: Every check compares against values built here.
`timescale 1ns/1ps
module cpsr_status_tb;
    import cpsr_pkg::*;
    localparam logic [7:0] A_ST = IDX_STATUS << 2;
    localparam logic [7:0] A_CT = IDX_CTRL << 2;
    localparam logic [7:0] A_MK = IDX_MASK << 2;
    localparam logic [7:0] A_EV = IDX_EVENT << 2;
    logic clk = 0, rst = 1, sw_reset = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = A_ST;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, irq, duplex_in, page_rx, an_complete, link_rt_in;
    logic tx_pause_in, rx_pause_in, an_enable, xover_auto_in, downshift_in;
    logic sleep_in, link_global_in, dte_power_in, polarity_in, jabber_in;
    logic [1:0] xover_mode, speed_in;
    logic [15:0] st = 0;
    logic [15:0] tv[4] = '{16'h0000, 16'h6F2F, 16'hA0BF, 16'h88C0};
    logic [1:0] xm[3] = '{XMODE_MDIX, XMODE_MDI, XMODE_AUTO};
    int failures = 0, samples_checked = 0, cyc = 0;
    always #50 clk = ~clk;
    cpsr_phy_model phy_u (.*);
    cpsr_status dut_u (.*);
    function automatic logic [31:0] ev(input logic [15:0] s, input logic x);
        ev = {16'h0, s[15:13], 1'b0, ~s[7] | s[11], s[10:8], 1'b0, x, s[5:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rs(input logic [15:0] s, input logic [31:0] e);
        st <= s;
        xfer(0, A_ST, 0);
        chk(rd, e);
    endtask
    task automatic results;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            failures++;
            results();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        chk(prdata, 32'h8040);
        rst <= 1'b0;
        foreach (tv[i]) rs(tv[i], ev(tv[i], tv[i][6]));
        rs(16'h1000, 32'h1800);
        rs(16'h0000, 32'h1800);
        rs(16'h0000, 32'h0800);
        $display("test fields finished");
        foreach (xm[i])
        begin
            xfer(1, A_CT, {25'h0, xm[i], 5'h0});
            chk(xover_mode, i ? xm[i-1] : XMODE_AUTO);
            sw_reset <= 1'b1;
            @(posedge clk);
            sw_reset <= 1'b0;
            rs(16'h0000, ev(16'h0000, i == 0));
            chk(xover_mode, xm[i]);
        end
        $display("test crossover finished");
        rs(16'h0002, 32'h0802);
        xfer(1, A_CT, 32'h62);
        rs(16'h0002, 32'h0800);
        rs(16'h4002, 32'h4802);
        $display("test polarity finished");
        rs(16'h0000, 32'h0800);
        xfer(1, A_EV, 32'hFFFF);
        xfer(1, A_MK, 32'h0001);
        rs(16'h0001, 32'h0801);
        chk(irq, 1'b1);
        xfer(0, A_EV, 0);
        chk(rd, 32'h1);
        xfer(1, A_MK, 0);
        xfer(0, A_EV, 0);
        chk(irq, 1'b0);
        xfer(1, A_EV, 32'h1);
        xfer(0, A_EV, 0);
        chk(rd, 32'h0);
        xfer(0, 8'h80, 0);
        chk(rd, 32'h0);
        chk({pready, pslverr}, 2'b10);
        $display("test interrupt finished");
        results();
    end
endmodule // cpsr_status_tb
